// ==== hw/dpui_core.v ====
// DRAM device-side power-up, reset and access framing logic with an APB view.
// Assumes pins are synchronous to pclk; ctrl_reset_n is the chip reset from the controller.
//
// Function
// - Reset clears gear-down, per-device addressing, power saving, latencies and repair modes.
// - Device runs its internal initialization after reset without needing the clock.
// - Termination stays high impedance in reset and until clock enable samples high.
// - Access starts with row activate carrying bank group, bank and row.
// - Column commands take column, auto-precharge from A10, chop from A12.
// - Two words per clock at pins; eight half-clock words per access.
// - x4/x8 parts have four bank groups; x16 parts have two.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dpui_regs.vh"

module dpui_core
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ctrl_reset_n,
  input  wire        boundary_scan_enable_pin,
  input  wire        clock_enable,
  input  wire        termination_control_pin,
  output reg         termination_active,
  output reg         init_done,
  output reg         burst_active,
  output reg         data_beat
);

  localparam [4:0] ST_RESET = 5'h01;
  localparam [4:0] ST_INIT  = 5'h02;
  localparam [4:0] ST_WAIT  = 5'h04;
  localparam [4:0] ST_CFG   = 5'h08;
  localparam [4:0] ST_READY = 5'h10;

  reg [4:0]  state;
  reg [17:0] mode_reg [0:`DPUI_NUM_MR-1];
  reg [15:0] init_cnt;
  reg [2:0]  mr_sel;
  reg [1:0]  org;
  reg [3:0]  bank_open;
  reg [17:0] row_addr;
  reg [9:0]  col_addr;
  reg        auto_pre;
  reg [3:0]  beats_left;
  reg        nominal_termination;
  reg        term_sample;
  reg        zq_done;
  reg        cmd_error;
  reg [2:0]  next_mr_order;
  integer    i;

  wire       apb_wr = psel && penable && pwrite;
  wire       apb_rd = psel && !penable && !pwrite;
  wire [2:0] cmd    = pwdata[`DPUI_CTRL_CMD_MSB:`DPUI_CTRL_CMD_LSB];
  wire       cmd_go = apb_wr && (paddr == `DPUI_OFF_CTRL) && pwdata[`DPUI_CTRL_CMD_BIT];
  wire [17:0] cmd_addr = pwdata[`DPUI_CTRL_ADDR_MSB:`DPUI_CTRL_ADDR_LSB];
  wire [3:0]  cmd_bank = pwdata[`DPUI_CTRL_BANK_MSB:`DPUI_CTRL_BANK_LSB];

  // Expected mode register number for each step of the write sequence.
  function [2:0] dpui_mr_at;
    input [2:0] step;
    begin
      case (step)
        3'h0:    dpui_mr_at = 3'h3;
        3'h1:    dpui_mr_at = 3'h6;
        3'h2:    dpui_mr_at = 3'h5;
        3'h3:    dpui_mr_at = 3'h4;
        3'h4:    dpui_mr_at = 3'h2;
        3'h5:    dpui_mr_at = 3'h1;
        default: dpui_mr_at = 3'h0;
      endcase
    end
  endfunction

  // Bank groups available for the organisation; x16 reaches only two.
  function dpui_bank_ok;
    input [1:0] o;
    input [3:0] b;
    begin
      dpui_bank_ok = (o != `DPUI_ORG_X16) || !b[3];
    end
  endfunction

  // The internal initialization and termination reset follow the chip reset pin, not
  // the command clock enable.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state               <= ST_RESET;
      init_cnt            <= 16'h0000;
      next_mr_order       <= 3'h0;
      termination_active  <= 1'b0;
      init_done           <= 1'b0;
      nominal_termination <= 1'b0;
      term_sample         <= 1'b0;
      zq_done             <= 1'b0;
      cmd_error           <= 1'b0;
      bank_open           <= 4'h0;
      row_addr            <= 18'h00000;
      col_addr            <= 10'h000;
      auto_pre            <= 1'b0;
      beats_left          <= 4'h0;
      burst_active        <= 1'b0;
      data_beat           <= 1'b0;
      for (i = 0; i < `DPUI_NUM_MR; i = i + 1)
        mode_reg[i] <= `DPUI_MR_DEFAULT;
    end
    else if (!ctrl_reset_n)
    begin
      state              <= ST_RESET;
      init_cnt           <= 16'h0000;
      next_mr_order      <= 3'h0;
      termination_active <= 1'b0;
      init_done          <= 1'b0;
      zq_done            <= 1'b0;
      beats_left         <= 4'h0;
      burst_active       <= 1'b0;
      data_beat          <= 1'b0;
      // Documented defaults are cleared; others stay undefined for software.
      mode_reg[3][`DPUI_MR3_GEAR] <= 1'b0;
      mode_reg[3][`DPUI_MR3_PDA]  <= 1'b0;
      mode_reg[4][`DPUI_MR4_MPS]  <= 1'b0;
      mode_reg[4][`DPUI_MR4_SOFT_POST_PACKAGE_REPAIR] <= 1'b0;
      mode_reg[4][`DPUI_MR4_HARD_POST_PACKAGE_REPAIR] <= 1'b0;
      mode_reg[4][`DPUI_MR4_CAL_MSB:`DPUI_MR4_CAL_LSB] <= 3'h0;
      mode_reg[5][`DPUI_MR5_PAR_MSB:0] <= 3'h0;
    end
    else
    begin
      // The clear sits ahead of every set so a fault in the same cycle stays recorded.
      if (apb_wr && paddr == `DPUI_OFF_STATUS && pwdata[`DPUI_STATUS_CLR_BIT])
        cmd_error <= 1'b0;
      case (state)
        ST_RESET:
          state <= ST_INIT;
        ST_INIT:
        begin
          if (init_cnt == `DPUI_INIT_WAIT_CYC - 1)
            state <= ST_WAIT;
          else
            init_cnt <= init_cnt + 16'h0001;
        end
        ST_WAIT:
        begin
          if (clock_enable)
          begin
            state              <= ST_CFG;
            term_sample        <= termination_control_pin;
            termination_active <= 1'b1;
          end
        end
        ST_CFG:
        begin
          if (!clock_enable || termination_control_pin != term_sample
              || boundary_scan_enable_pin)
            cmd_error <= 1'b1;
        end
        ST_READY:
        begin
        end
        default:
        begin
          state <= ST_RESET;
        end
      endcase

      data_beat <= burst_active;
      if (beats_left != 4'h0)
        beats_left <= beats_left - 4'h1;
      burst_active <= (beats_left > 4'h1);

      if (cmd_go && state != ST_RESET && state != ST_INIT)
      begin
        case (cmd)
          `DPUI_CMD_MRW:
          begin
            if (state == ST_CFG && next_mr_order < 3'h7
                && mr_sel != dpui_mr_at(next_mr_order))
              cmd_error <= 1'b1;
            mode_reg[mr_sel] <= cmd_addr;
            if (state == ST_CFG && mr_sel == dpui_mr_at(next_mr_order))
              next_mr_order <= next_mr_order + 3'h1;
          end
          `DPUI_CMD_ZQCAL:
          begin
            if (state == ST_CFG && next_mr_order == 3'h7)
            begin
              zq_done   <= 1'b1;
              state     <= ST_READY;
              init_done <= 1'b1;
              nominal_termination <= !term_sample;
            end
          end
          `DPUI_CMD_ACT:
          begin
            if (state == ST_READY && dpui_bank_ok(org, cmd_bank))
            begin
              bank_open <= cmd_bank;
              row_addr  <= cmd_addr;
            end
            else
              cmd_error <= 1'b1;
          end
          `DPUI_CMD_RD, `DPUI_CMD_WR:
          begin
            if (state == ST_READY)
            begin
              col_addr <= cmd_addr[9:0];
              auto_pre <= cmd_addr[`DPUI_A_AUTO_PRE];
              if (mode_reg[0][`DPUI_MR_OTF_LSB+1:`DPUI_MR_OTF_LSB] == `DPUI_MR_OTF_VAL
                  && !cmd_addr[`DPUI_A_CHOP])
                beats_left <= `DPUI_BURST_CHOP;
              else
                beats_left <= `DPUI_BURST_FULL;
              burst_active <= 1'b1;
            end
            else
              cmd_error <= 1'b1;
          end
          `DPUI_CMD_NOP:
          begin
            if (!mode_reg[4][`DPUI_MR4_MPS] && !mode_reg[3][`DPUI_MR3_GEAR])
              cmd_error <= 1'b1;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // APB registers; every transfer completes in the access phase with no wait.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      mr_sel  <= 3'h0;
      org     <= 2'h0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        if (paddr != `DPUI_OFF_CTRL && paddr != `DPUI_OFF_STATUS
            && paddr != `DPUI_OFF_MR_SEL && paddr != `DPUI_OFF_MR_DATA
            && paddr != `DPUI_OFF_ACCESS && paddr != `DPUI_OFF_CONFIG)
          pslverr <= 1'b1;
      end
      if (apb_wr && paddr == `DPUI_OFF_MR_SEL)
        mr_sel <= pwdata[2:0];
      else if (apb_wr && paddr == `DPUI_OFF_CONFIG)
        org <= pwdata[1:0];
      if (apb_rd)
      begin
        if (paddr == `DPUI_OFF_STATUS)
          prdata <= {24'h000000, nominal_termination, zq_done, cmd_error, state};
        else if (paddr == `DPUI_OFF_MR_SEL)
          prdata <= {29'h00000000, mr_sel};
        else if (paddr == `DPUI_OFF_MR_DATA)
          prdata <= {14'h0000, mode_reg[mr_sel]};
        else if (paddr == `DPUI_OFF_ACCESS)
          prdata <= {auto_pre, col_addr[2:0], bank_open, row_addr, 2'h0, beats_left};
        else if (paddr == `DPUI_OFF_CONFIG)
          prdata <= {27'h0000000, next_mr_order, org};
        else
          prdata <= 32'h00000000;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/dpui_regs.vh ====
// Constants for the DRAM power-up initialization block: APB map, fields, resets, timing.
// Assumes a 50 MHz pclk; included by the design file, the controller model and the bench.
`ifndef DPUI_REGS_VH
`define DPUI_REGS_VH

`define DPUI_CLK_MHZ          50
// Register byte offsets.
`define DPUI_OFF_CTRL         12'h000
`define DPUI_OFF_STATUS       12'h004
`define DPUI_OFF_MR_SEL       12'h008
`define DPUI_OFF_MR_DATA      12'h00C
`define DPUI_OFF_ACCESS       12'h010
`define DPUI_OFF_CONFIG       12'h014
// Control fields.
`define DPUI_CTRL_CMD_BIT     0
`define DPUI_CTRL_CMD_LSB     1
`define DPUI_CTRL_CMD_MSB     3
`define DPUI_CTRL_ADDR_LSB    8
`define DPUI_CTRL_ADDR_MSB    25
`define DPUI_CTRL_BANK_LSB    26
`define DPUI_CTRL_BANK_MSB    29
// Status write field.
`define DPUI_STATUS_CLR_BIT   4
// Command codes written to control.
`define DPUI_CMD_IDLE         3'h0
`define DPUI_CMD_MRW          3'h1
`define DPUI_CMD_ZQCAL        3'h2
`define DPUI_CMD_ACT          3'h3
`define DPUI_CMD_RD           3'h4
`define DPUI_CMD_WR           3'h5
`define DPUI_CMD_NOP          3'h6
// Mode register address bits.
`define DPUI_A_AUTO_PRE       10
`define DPUI_A_CHOP           12
`define DPUI_MR_OTF_LSB       1
`define DPUI_MR_OTF_VAL       2'h1
`define DPUI_MR3_GEAR         3
`define DPUI_MR3_PDA          4
`define DPUI_MR4_MPS          1
`define DPUI_MR4_SOFT_POST_PACKAGE_REPAIR         5
`define DPUI_MR4_CAL_LSB      6
`define DPUI_MR4_CAL_MSB      8
`define DPUI_MR4_HARD_POST_PACKAGE_REPAIR         13
`define DPUI_MR5_PAR_MSB      2
`define DPUI_MR_DEFAULT       18'h00000
`define DPUI_NUM_MR           7
// Timing.
`define DPUI_INIT_WAIT_US     500
`define DPUI_INIT_WAIT_CYC    (`DPUI_INIT_WAIT_US * `DPUI_CLK_MHZ)
`define DPUI_BURST_FULL       4'h8
`define DPUI_BURST_CHOP       4'h4
// Organisation codes in config.
`define DPUI_ORG_X16          2'h2

`endif

// ==== test/dpui_core_checker.sv ====
// Assertions on the pin outputs and APB answer of dpui_core.
// Assumes it is bound to dpui_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dpui_core_checker
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire ctrl_reset_n,
  input wire clock_enable,
  input wire termination_active,
  input wire init_done,
  input wire burst_active,
  input wire data_beat
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go;
    $rose(burst_active);
  endsequence
  sequence s_end;
    ##[4:8] $fell(burst_active);
  endsequence
  a_term_in_reset: assert property (!ctrl_reset_n |=> !termination_active)
    else $error("termination on in chip reset");
  a_term_needs_cke: assert property ($rose(termination_active) |-> $past(clock_enable))
    else $error("termination on without clock enable");
  a_burst_min: assert property (s_go |-> burst_active [*4])
    else $error("burst shorter than four");
  a_burst_len: assert property (s_go |-> s_end)
    else $error("burst not ended in eight");
  a_beat_lag: assert property (s_go |=> data_beat [*4])
    else $error("beats do not follow burst");
  a_done_reset: assert property (!ctrl_reset_n |=> !init_done)
    else $error("init done kept in chip reset");
  a_burst_reset: assert property (!ctrl_reset_n |=> !burst_active)
    else $error("burst kept in chip reset");
  a_done_term_on: assert property (init_done |-> termination_active)
    else $error("init done without termination enabled");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
endmodule
bind dpui_core dpui_core_checker dpui_core_checker_inst (.pclk, .presetn, .psel, .penable,
  .pready, .ctrl_reset_n, .clock_enable, .termination_active, .init_done, .burst_active,
  .data_beat);
`default_nettype wire

// ==== test/dpui_ctrl_model.sv ====
// Behavioural memory controller driving the chip reset, clock enable and pins.
// Assumes the bench calls its tasks in power-up order.
`timescale 1ns/1ps
`default_nettype none
`include "dpui_regs.vh"
module dpui_ctrl_model #(parameter int RST_CYC = 10, parameter int XPR_CYC = 5,
  parameter int MRD_CYC = 4)
(
  input  wire pclk,
  output logic ctrl_reset_n,
  output logic clock_enable,
  output logic termination_control_pin,
  output logic boundary_scan_enable_pin
);
  initial
  begin
    ctrl_reset_n = 1'b0;
    clock_enable = 1'b0;
    termination_control_pin = 1'b0;
    boundary_scan_enable_pin = 1'b0;
  end
  task automatic hold_reset;
    @(posedge pclk);
    ctrl_reset_n <= 1'b0;
    clock_enable <= 1'b0;
    repeat (RST_CYC) @(posedge pclk);
  endtask
  task automatic release_reset;
    ctrl_reset_n <= 1'b1;
  endtask
  task automatic wait_init;
    repeat (`DPUI_INIT_WAIT_CYC + 10) @(posedge pclk);
  endtask
  task automatic raise_cke;
    @(posedge pclk);
    clock_enable <= 1'b1;
    repeat (XPR_CYC) @(posedge pclk);
  endtask
  task automatic mr_gap;
    repeat (MRD_CYC) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== test/dram_power_up_init_tb.sv ====
// Self-checking bench: power-up, mode register order, bursts and APB errors.
// Assumes dpui_core and the controller model are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "dpui_regs.vh"
module dram_power_up_init_tb;
  logic        pclk, presetn, psel, penable, pwrite, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd_data;
  wire  [31:0] prdata;
  wire         pready, pslverr, ctrl_reset_n, boundary_scan_enable_pin;
  wire         clock_enable, termination_control_pin;
  wire         termination_active, init_done, burst_active, data_beat;
  int          num_errors, cmp_count, beats;
  int          mr_order[7] = '{3, 6, 5, 4, 2, 1, 0};
  logic [31:0] mr_mask[3] = '{32'h00000018, 32'h000021E2, 32'h00000007};
  dpui_core dpui_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ctrl_reset_n, .boundary_scan_enable_pin, .clock_enable,
    .termination_control_pin, .termination_active, .init_done, .burst_active, .data_beat);
  dpui_ctrl_model dpui_ctrl_model_inst (.pclk, .ctrl_reset_n, .clock_enable,
    .termination_control_pin, .boundary_scan_enable_pin);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("Mismatches %0d of %0d compares", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      complete_run();
    end
    else
    begin
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic [17:0] a, input logic [3:0] b);
    apb(1'b1, `DPUI_OFF_CTRL, {2'h0, b, a, 4'h0, c, 1'b1});
  endtask
  task automatic st(input string nm, input logic [5:0] x);
    apb(1'b0, `DPUI_OFF_STATUS, 32'h0);
    chk(nm, {26'h0, x}, {26'h0, rd_data[5:0]});
  endtask
  task automatic burst(input logic [2:0] c, input logic [17:0] a, input int n);
    cmd(c, a, 4'h1);
    beats = 0;
    repeat (16)
    begin
      @(posedge pclk);
      beats += int'(data_beat === 1'b1);
    end
    chk("beats", n, beats);
  endtask
  task automatic mr_defaults;
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, `DPUI_OFF_MR_SEL, 32'(k + 3));
      apb(1'b0, `DPUI_OFF_MR_DATA, 32'h0);
      chk("mr_default", 0, rd_data & mr_mask[k]);
    end
  endtask
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    dpui_ctrl_model_inst.hold_reset();
    st("reset_state", 6'h01);
    chk("term_reset", 0, termination_active);
    dpui_ctrl_model_inst.release_reset();
    st("init_state", 6'h02);
    dpui_ctrl_model_inst.wait_init();
    st("wait_state", 6'h04);
    chk("term_wait", 0, termination_active);
    dpui_ctrl_model_inst.raise_cke();
    st("config_state", 6'h08);
    chk("term_on", 1, termination_active);
    mr_defaults();
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, `DPUI_OFF_MR_SEL, 32'(mr_order[i]));
      cmd(`DPUI_CMD_MRW, (mr_order[i] == 0) ? 18'h00002 : 18'h3FFFF, 4'h0);
      dpui_ctrl_model_inst.mr_gap();
    end
    cmd(`DPUI_CMD_ZQCAL, 18'h00000, 4'h0);
    repeat (2) @(posedge pclk);
    chk("init_done", 1, init_done);
    st("ready_state", 6'h10);
    cmd(`DPUI_CMD_NOP, 18'h00000, 4'h0);
    st("nop_allowed", 6'h10);
    cmd(`DPUI_CMD_ACT, 18'h00123, 4'h1);
    burst(`DPUI_CMD_RD, 18'h00000, 4);
    burst(`DPUI_CMD_WR, 18'h01000, 8);
    burst(`DPUI_CMD_RD, 18'h00400, 4);
    apb(1'b0, `DPUI_OFF_ACCESS, 32'h0);
    chk("auto_pre", 1, rd_data[31]);
    apb(1'b1, `DPUI_OFF_CONFIG, 32'h00000002);
    cmd(`DPUI_CMD_ACT, 18'h00000, 4'h8);
    st("bank_x16_bad", 6'h30);
    apb(1'b1, `DPUI_OFF_STATUS, 32'h00000010);
    cmd(`DPUI_CMD_ACT, 18'h00000, 4'h4);
    st("bank_x16_ok", 6'h10);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 1, rd_err);
    dpui_ctrl_model_inst.hold_reset();
    chk("done_clear", 0, init_done);
    mr_defaults();
    dpui_ctrl_model_inst.release_reset();
    dpui_ctrl_model_inst.wait_init();
    dpui_ctrl_model_inst.raise_cke();
    cmd(`DPUI_CMD_NOP, 18'h00000, 4'h0);
    st("nop_refused", 6'h28);
    apb(1'b1, `DPUI_OFF_STATUS, 32'h00000010);
    apb(1'b1, `DPUI_OFF_MR_SEL, 32'h00000006);
    cmd(`DPUI_CMD_MRW, 18'h00000, 4'h0);
    st("order_error", 6'h28);
    apb(1'b1, `DPUI_OFF_STATUS, 32'h00000010);
    st("error_clear", 6'h08);
    complete_run();
  end
endmodule
`default_nettype wire
